// ==== rtl/fpg_guard.sv ====
`timescale 1ns/1ps
`include "fpg_defines.svh"

// Behaviour
// R01: programming only clears bits; erase sets them
// R02: 512-byte pages; erase fills page with FF
// R03: hardware times operations; core stalled meanwhile
// R04: keys A5 then F1 arm one operation
// R05: wrong key order or value locks out flash
// R06: flash attempt without keys also locks out
// R07: key relocks after each completed operation
// R08: write-enable routes writes to flash; reads RAM
// R09: program needs write enable; erase needs both
// R10: erase write clears whole addressed page
// R11: block select picks one or two bytes
// R12: single-byte mode programs after every write
// R13: block programs after odd address write only
// R14: software writes even first, rekeys each byte
// R15: software pads unchanged block byte with FF
// R16: software keeps monitor on, sets read time
// R17: ones complement of lock byte locks pages
// R18: lock-byte page locked whenever any page is
// R19: debug port denied locked pages, lock byte rules
// R20: unlocked code denied locked and lock pages
// R21: locked code reaches all but lock erase
// R22: reserved or forbidden access forces error reset
// R23: key register read shows key state
// R24: flash error flag set after error reset
// R25: page number from address bits nine upward
// R26: lock-out persists until system reset
module fpg_guard import fpg_pkg::*; #(
	parameter bit FLASH_64K = 1'b1,
	parameter int PROG_CYC  = (`FPG_PROG_NS + `FPG_CLK_NS - 1)
		/ `FPG_CLK_NS,
	parameter int ERASE_CYC = (`FPG_ERASE_NS + `FPG_CLK_NS - 1)
		/ `FPG_CLK_NS
) (
	input  wire logic        core_clk,           // 10 MHz core clock
	input  wire logic        arst_n,             // Power-on reset
	input  wire logic        sys_reset,          // System reset pulse
	input  wire logic        key_wr,             // Key register write
	input  wire logic [7:0]  key_wdata,          // Key byte written
	output logic      [1:0]  key_state,          // Key register read
	input  wire logic        store_write_enable, // Writes go to flash
	input  wire logic        store_erase_enable, // Writes erase pages
	input  wire logic        block_write_select, // Two-byte blocks
	input  wire logic        xw_valid,           // External write
	input  wire logic [15:0] xw_addr,            // Its address
	input  wire logic [7:0]  xw_data,            // Its data
	input  wire logic        xr_valid,           // External read
	output logic             ram_wr_en,          // Write to data RAM
	output logic             ram_rd_en,          // Read from data RAM
	input  wire logic        cm_valid,           // Code read of flash
	input  wire logic [15:0] cm_addr,            // Its address
	input  wire logic [15:0] exec_pc,            // Running code address
	input  wire logic [7:0]  lock_byte,          // Stored lock byte
	input  wire logic [15:0] flash_cur_word,     // Word at xw_addr
	output logic             core_stall,         // Hold the core
	output logic             fl_prog,            // Program pulse
	output logic             fl_erase,           // Page or whole-array erase pulse
	output logic             fl_mass,            // Whole-array erase
	output logic             fl_busy,            // Operation running
	output logic      [15:0] fl_addr,            // Word or page address
	output logic      [15:0] fl_wdata,           // Word to program
	input  wire logic        dbg_valid,          // Debug port request
	input  wire logic [1:0]  dbg_op,             // Debug operation
	input  wire logic [15:0] dbg_addr,           // Debug address
	input  wire logic [7:0]  dbg_wdata,          // Debug data
	output logic             dbg_grant,          // Debug request ok
	output logic             dbg_deny,           // Debug request refused
	output logic             flash_err_rst,      // Request error reset
	output logic             flash_error_flag    // Last reset was error
);
	localparam logic [17:0] PROG_LAST  = 18'(PROG_CYC - 1);
	localparam logic [17:0] ERASE_LAST = 18'(ERASE_CYC - 1);
	localparam logic [6:0]  LOCK_PG    = FLASH_64K ?
		`FPG_LOCK_PAGE_64K : `FPG_LOCK_PAGE_32K;

	logic [1:0] rsync_q;
	logic       rst_n;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n)
			rsync_q <= 2'b00;
		else
			rsync_q <= {rsync_q[0], 1'b1};
	end
	assign rst_n = rsync_q[1];

	fpg_main_t s_q;
	fpg_main_t s_d;

	logic armed;
	logic attempt;
	logic consume;
	logic fw_ok;
	logic cm_ok;
	logic dbg_ok;
	logic idle;
	logic flash_tgt;
	logic erase_req;
	logic dbg_rd;
	logic dbg_er;

	assign idle      = s_q.st == FPG_IDLE;
	assign flash_tgt = xw_valid && store_write_enable;  // R08
	assign erase_req = flash_tgt && store_erase_enable;  // R09
	assign dbg_rd    = dbg_op == FPG_DBG_RD;
	assign dbg_er    = dbg_op == FPG_DBG_ER;

	fpg_key_fsm u_key (
		.core_clk  (core_clk),
		.rst_n     (rst_n),
		.sys_reset (sys_reset),
		.key_wr    (key_wr),
		.key_wdata (key_wdata),
		.attempt   (attempt),
		.consume   (consume),
		.armed     (armed),
		.key_state (key_state)
	);

	fpg_access_check #(.FLASH_64K(FLASH_64K)) u_fw_chk (
		.lock_byte  (lock_byte),
		.from_debug (1'b0),
		.exec_pc    (exec_pc),
		.addr       (xw_addr),
		.op_rd      (1'b0),
		.op_er      (store_erase_enable),
		.op_wr      (!store_erase_enable),
		.wdata      (xw_data),
		.allow      (fw_ok)
	);

	fpg_access_check #(.FLASH_64K(FLASH_64K)) u_cm_chk (
		.lock_byte  (lock_byte),
		.from_debug (1'b0),
		.exec_pc    (exec_pc),
		.addr       (cm_addr),
		.op_rd      (1'b1),
		.op_er      (1'b0),
		.op_wr      (1'b0),
		.wdata      (`FPG_ERASED_BYTE),
		.allow      (cm_ok)
	);

	fpg_access_check #(.FLASH_64K(FLASH_64K)) u_dbg_chk (
		.lock_byte  (lock_byte),
		.from_debug (1'b1),
		.exec_pc    (exec_pc),
		.addr       (dbg_addr),
		.op_rd      (dbg_rd),
		.op_er      (dbg_er),
		.op_wr      (dbg_op == FPG_DBG_WR),
		.wdata      (dbg_wdata),
		.allow      (dbg_ok)
	);

	// A forbidden target never reaches the key, so it cannot lock out
	assign attempt = idle && flash_tgt && fw_ok && !armed;  // R06
	// Key is freed when an operation ends or an even byte is held
	assign consume = (s_q.st != FPG_IDLE && s_q.cnt == 18'h0) ||
		(idle && flash_tgt && fw_ok && armed && !erase_req &&
		block_write_select && !xw_addr[0]);  // R07 R14

	assign ram_wr_en = xw_valid && !store_write_enable;  // R08
	assign ram_rd_en = xr_valid;  // R08

	always_comb begin
		logic [15:0] word;
		word = `FPG_ERASED_WORD;
		s_d = s_q;
		s_d.fl_prog   = 1'b0;
		s_d.fl_erase  = 1'b0;
		s_d.dbg_grant = 1'b0;
		s_d.dbg_deny  = 1'b0;
		s_d.err_rst   = 1'b0;
		case (s_q.st)
		FPG_IDLE: begin
			if (flash_tgt && !fw_ok) begin
				s_d.err_rst = 1'b1;  // R22
			end else if (flash_tgt && armed) begin
				if (erase_req) begin
					s_d.st       = FPG_ERASE;  // R10
					s_d.cnt      = ERASE_LAST;
					s_d.fl_erase = 1'b1;
					s_d.fl_mass  = 1'b0;
					s_d.fl_addr  = {xw_addr[15:`FPG_PAGE_LSB],
						`FPG_PAGE_BASE};  // R02 R25
				end else if (block_write_select && !xw_addr[0]) begin
					s_d.lo_pend = 1'b1;  // R13
					s_d.lo_addr = xw_addr;
					s_d.lo_data = xw_data;
				end else begin
					// Unwritten lane stays FF so its cells keep their state
					if (xw_addr[0])
						word[15:8] = xw_data;
					else
						word[7:0] = xw_data;  // R12
					if (block_write_select && s_q.lo_pend &&
						s_q.lo_addr == {xw_addr[15:1], 1'b0})
						word[7:0] = s_q.lo_data;  // R11 R13
					s_d.lo_pend  = 1'b0;
					s_d.st       = FPG_PROG;  // R03
					s_d.cnt      = PROG_LAST;
					s_d.fl_prog  = 1'b1;
					s_d.fl_addr  = {xw_addr[15:1], 1'b0};
					s_d.fl_wdata = word & flash_cur_word;  // R01
				end
			end else if (cm_valid && !cm_ok) begin
				s_d.err_rst = 1'b1;  // R22
			end else if (dbg_valid) begin
				if (dbg_op == FPG_DBG_DEV) begin
					s_d.st       = FPG_ERASE;  // R19
					s_d.cnt      = ERASE_LAST;
					s_d.fl_erase = 1'b1;
					s_d.fl_mass  = 1'b1;
					s_d.dbg_grant = 1'b1;
				end else begin
					s_d.dbg_grant = dbg_ok;  // R19
					s_d.dbg_deny  = !dbg_ok;
				end
			end
		end
		FPG_PROG, FPG_ERASE: begin
			if (dbg_valid)
				s_d.dbg_deny = 1'b1;
			if (s_q.cnt == 18'h0)
				s_d.st = FPG_IDLE;  // R03
			else
				s_d.cnt = s_q.cnt - 18'h1;
		end
		default: s_d.st = FPG_IDLE;
		endcase
		if (s_d.err_rst)
			s_d.err_pend = 1'b1;
		// The flag outlives the system reset it caused
		if (sys_reset) begin
			s_d.err_flag = s_q.err_pend;  // R24
			s_d.err_pend = s_d.err_rst;
			s_d.lo_pend  = 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign core_stall       = !idle;  // R03
	assign fl_busy          = !idle;
	assign fl_prog          = s_q.fl_prog;
	assign fl_erase         = s_q.fl_erase;
	assign fl_mass          = s_q.fl_mass;
	assign fl_addr          = s_q.fl_addr;
	assign fl_wdata         = s_q.fl_wdata;
	assign dbg_grant        = s_q.dbg_grant;
	assign dbg_deny         = s_q.dbg_deny;
	assign flash_err_rst    = s_q.err_rst;
	assign flash_error_flag = s_q.err_flag;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	no_set_bits_a: assert property (  // R01
		fl_prog |-> (fl_wdata & ~$past(flash_cur_word)) == 16'h0)
		else $error("program would set a bit");
	page_align_a: assert property (  // R02
		fl_erase && !fl_mass |-> fl_addr[8:0] == `FPG_PAGE_BASE)
		else $error("erase address not page aligned");
	// A repetition count cannot follow PROG_CYC, so check cycle by cycle
	stall_hold_a: assert property (  // R03
		(fl_prog |-> core_stall) and
		(!idle && s_q.cnt != 18'h0 |=> core_stall))
		else $error("core not stalled during program");
	ram_route_a: assert property (  // R08
		flash_tgt |-> !ram_wr_en)
		else $error("flash write also reached RAM");
	erase_enable_a: assert property (  // R09
		fl_erase && !fl_mass |->
		$past(store_write_enable && store_erase_enable && armed))
		else $error("erase without both enables and key");
	odd_start_a: assert property (  // R13
		fl_prog && $past(block_write_select) |-> $past(xw_addr[0]))
		else $error("block program started on even byte");
	err_reset_a: assert property (  // R22
		idle && flash_tgt && !fw_ok |=> flash_err_rst)
		else $error("forbidden access gave no error reset");
	// Checked here on the core clock; the checker itself has no clock
	fw_lock_page_a: assert property (  // R20 R21
		idle && erase_req && xw_addr[15:`FPG_PAGE_LSB] == LOCK_PG
		|=> flash_err_rst && !fl_erase)
		else $error("firmware allowed to erase lock page");
	err_flag_a: assert property (  // R24
		s_q.err_pend && sys_reset |=> flash_error_flag)
		else $error("error flag not set after error reset");

	prog_c: cover property (fl_prog ##[1:500] !core_stall);
	block_c: cover property (fl_prog && fl_wdata[7:0] != 8'hFF
		&& fl_wdata[15:8] != 8'hFF);
	erase_c: cover property (fl_erase && !fl_mass);
	err_c: cover property (flash_err_rst);

endmodule : fpg_guard

// ==== rtl/fpg_defines.svh ====
`ifndef FPG_DEFINES_SVH
`define FPG_DEFINES_SVH

// Key codes, written in this order to arm one operation
`define FPG_KEY_FIRST   8'hA5
`define FPG_KEY_SECOND  8'hF1

// Page geometry: 512-byte pages
`define FPG_PAGE_LSB    9
`define FPG_PAGE_W      7
`define FPG_PAGE_OFS_W  9
`define FPG_PAGE_BASE   9'h000
`define FPG_ERASED_BYTE 8'hFF
`define FPG_ERASED_WORD 16'hFFFF

// Lock byte and its page, per flash size
`define FPG_LOCK_ADDR_64K 16'hFBFF
`define FPG_LOCK_ADDR_32K 16'h7FFF
`define FPG_LOCK_PAGE_64K 7'h7D
`define FPG_LOCK_PAGE_32K 7'h3F

// Timing
`define FPG_CLK_NS      100
`define FPG_PROG_NS     40000
`define FPG_ERASE_NS    20000000
`define FPG_CNT_W       18

`endif

// ==== rtl/fpg_pkg.sv ====
package fpg_pkg;

	typedef enum logic [1:0] {
		FPG_KEY_LOCKED = 2'b00,
		FPG_KEY_HALF   = 2'b01,
		FPG_KEY_ARMED  = 2'b10,
		FPG_KEY_OUT    = 2'b11
	} fpg_key_t;

	typedef enum logic [1:0] {
		FPG_IDLE  = 2'b00,
		FPG_PROG  = 2'b01,
		FPG_ERASE = 2'b10
	} fpg_op_t;

	typedef enum logic [1:0] {
		FPG_DBG_RD  = 2'b00,
		FPG_DBG_WR  = 2'b01,
		FPG_DBG_ER  = 2'b10,
		FPG_DBG_DEV = 2'b11
	} fpg_dbg_t;

	typedef struct packed {
		fpg_key_t ks;
	} fpg_key_st_t;

	typedef struct packed {
		fpg_op_t       st;
		logic [17:0]   cnt;
		logic          lo_pend;
		logic [15:0]   lo_addr;
		logic [7:0]    lo_data;
		logic [15:0]   fl_addr;
		logic [15:0]   fl_wdata;
		logic          fl_prog;
		logic          fl_erase;
		logic          fl_mass;
		logic          dbg_grant;
		logic          dbg_deny;
		logic          err_rst;
		logic          err_pend;
		logic          err_flag;
	} fpg_main_t;

endpackage : fpg_pkg

// ==== rtl/fpg_key_fsm.sv ====
`timescale 1ns/1ps
`include "fpg_defines.svh"

module fpg_key_fsm import fpg_pkg::*; (
	input  wire logic       core_clk,   // Core clock
	input  wire logic       rst_n,      // Synchronised reset
	input  wire logic       sys_reset,  // System reset pulse
	input  wire logic       key_wr,     // Key register write
	input  wire logic [7:0] key_wdata,  // Key byte
	input  wire logic       attempt,    // Flash write or erase tried
	input  wire logic       consume,    // Operation used the key
	output logic            armed,      // One operation allowed
	output logic [1:0]      key_state   // Readback of key state
);
	fpg_key_st_t s_q;
	fpg_key_st_t s_d;

	always_comb begin
		s_d = s_q;
		case (s_q.ks)
		FPG_KEY_LOCKED: begin
			if (attempt)
				s_d.ks = FPG_KEY_OUT;  // R06
			else if (key_wr)
				s_d.ks = (key_wdata == `FPG_KEY_FIRST) ?
					FPG_KEY_HALF : FPG_KEY_OUT;  // R04
		end
		FPG_KEY_HALF: begin
			if (attempt)
				s_d.ks = FPG_KEY_OUT;  // R06
			else if (key_wr)
				s_d.ks = (key_wdata == `FPG_KEY_SECOND) ?
					FPG_KEY_ARMED : FPG_KEY_OUT;  // R05
		end
		FPG_KEY_ARMED: begin
			// A third key write before using the key is out of order
			if (key_wr)
				s_d.ks = FPG_KEY_OUT;  // R05
			else if (consume)
				s_d.ks = FPG_KEY_LOCKED;  // R07
		end
		FPG_KEY_OUT: s_d.ks = FPG_KEY_OUT;  // R26
		default: s_d.ks = FPG_KEY_OUT;
		endcase
		if (sys_reset)
			s_d.ks = FPG_KEY_LOCKED;
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			s_q <= '{ks: FPG_KEY_LOCKED};
		else
			s_q <= s_d;
	end

	assign armed     = (s_q.ks == FPG_KEY_ARMED);
	assign key_state = s_q.ks;  // R23

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	// Any spacing between the two codes is legal, so check the last step
	key_order_a: assert property (  // R04
		s_q.ks == FPG_KEY_HALF && key_wr && !attempt && !sys_reset
		&& key_wdata == `FPG_KEY_SECOND |=> armed)
		else $error("key sequence did not arm");
	lockout_hold_a: assert property (  // R26
		s_q.ks == FPG_KEY_OUT && !sys_reset |=> s_q.ks == FPG_KEY_OUT)
		else $error("lock-out left without reset");
	bad_key_a: assert property (  // R05
		s_q.ks == FPG_KEY_HALF && key_wr && !sys_reset
		&& key_wdata != `FPG_KEY_SECOND |=> !armed [*4])
		else $error("wrong key still armed");
	early_try_a: assert property (  // R06
		attempt && !armed && !sys_reset |=> s_q.ks == FPG_KEY_OUT)
		else $error("attempt without key not locked out");
	key_used_a: assert property (  // R07
		armed && consume && !key_wr && !sys_reset |=> !armed)
		else $error("key not relocked after operation");
	armed_c: cover property (armed ##[1:50] consume);

endmodule : fpg_key_fsm

// ==== rtl/fpg_access_check.sv ====
`timescale 1ns/1ps
`include "fpg_defines.svh"

module fpg_access_check import fpg_pkg::*; #(
	parameter bit FLASH_64K = 1'b1
) (
	input  wire logic [7:0]  lock_byte,   // Current lock byte value
	input  wire logic        from_debug,  // Request from debug port
	input  wire logic [15:0] exec_pc,     // Address of running code
	input  wire logic [15:0] addr,        // Target address
	input  wire logic        op_rd,       // Read
	input  wire logic        op_er,       // Erase
	input  wire logic        op_wr,       // Program
	input  wire logic [7:0]  wdata,       // Data to program
	output logic             allow        // Access permitted
);
	localparam logic [15:0] LOCK_ADDR = FLASH_64K ?
		`FPG_LOCK_ADDR_64K : `FPG_LOCK_ADDR_32K;
	localparam logic [6:0] LOCK_PAGE = FLASH_64K ?
		`FPG_LOCK_PAGE_64K : `FPG_LOCK_PAGE_32K;

	function automatic logic [6:0] page_of(input logic [15:0] a);
		page_of = a[`FPG_PAGE_LSB +: `FPG_PAGE_W];  // R25
	endfunction : page_of

	// n locked pages from page 0, plus the lock page when n > 0
	function automatic logic is_locked(input logic [6:0] pg,
		input logic [7:0] lb);
		logic [7:0] n;
		n = ~lb;  // R17
		is_locked = ({1'b0, pg} < n) ||
			(pg == LOCK_PAGE && n != 8'h00);  // R18
	endfunction : is_locked

	logic reserved;
	logic lock_pg;
	logic tgt_lock;
	logic code_lock;
	logic lock_adr;
	logic lock_tighten;

	assign reserved  = addr > LOCK_ADDR;  // R22
	assign lock_pg   = page_of(addr) == LOCK_PAGE;
	assign lock_adr  = addr == LOCK_ADDR;
	assign tgt_lock  = is_locked(page_of(addr), lock_byte);
	assign code_lock = is_locked(page_of(exec_pc), lock_byte);
	// Programming only clears bits, so any cleared bit would lock more
	assign lock_tighten = op_wr && lock_adr &&
		((lock_byte & ~wdata) != 8'h00);  // R22

	always_comb begin
		allow = !reserved && !lock_tighten;
		if (from_debug)
			allow = allow && (!tgt_lock || (op_rd && lock_adr));  // R19
		else
			allow = allow && !(op_er && lock_pg) &&
				(!tgt_lock || code_lock || (op_rd && lock_adr));  // R20 R21
	end

endmodule : fpg_access_check

// ==== bench/fpg_flash_model.sv ====
`timescale 1ns/1ps
// Byte array behind the guard; every byte starts erased
module fpg_flash_model #(
	parameter bit FLASH_64K = 1'b1
) (
	input  wire logic        core_clk,  // Core clock
	input  wire logic        fl_prog,   // Program pulse
	input  wire logic        fl_erase,  // Erase pulse
	input  wire logic        fl_mass,   // Whole-array erase
	input  wire logic [15:0] fl_addr,   // Word or page address
	input  wire logic [15:0] fl_wdata,  // Word to program
	input  wire logic [15:0] rd_addr,   // Address of current word
	output logic      [15:0] cur_word,  // Word holding rd_addr
	output logic      [7:0]  lock_byte  // Stored lock byte
);
	logic [7:0]  mem [0:65535];
	logic [15:0] lock_addr;

	assign lock_addr = FLASH_64K ? 16'hFBFF : 16'h7FFF;
	assign lock_byte = mem[lock_addr];
	assign cur_word  = {mem[{rd_addr[15:1], 1'b1}], mem[{rd_addr[15:1], 1'b0}]};

	initial begin
		for (int i = 0; i < 65536; i++)
			mem[i] = 8'hFF;
	end

	always @(posedge core_clk) begin
		// Cells can only be pulled low by programming
		if (fl_prog === 1'b1) begin
			mem[{fl_addr[15:1], 1'b0}] &= fl_wdata[7:0];
			mem[{fl_addr[15:1], 1'b1}] &= fl_wdata[15:8];
		end
		if (fl_erase === 1'b1) begin
			for (int i = 0; i < 65536; i++)
				if (fl_mass || i[15:9] == fl_addr[15:9])
					mem[i] = 8'hFF;
		end
	end
endmodule : fpg_flash_model

// ==== bench/test_fpg_guard.sv ====
`timescale 1ns/1ps
module test_fpg_guard import fpg_pkg::*;;
	localparam int PCYC = 4;
	localparam int ECYC = 10;
	logic        core_clk, arst_n, sys_reset, key_wr, xw_valid, xr_valid;
	logic        swe, see, bws, cm_valid, dbg_valid, rw, l_mass;
	logic        ram_wr_en, ram_rd_en, core_stall, fl_prog, fl_erase, fl_mass;
	logic        fl_busy, dbg_grant, dbg_deny, flash_err_rst, flash_error_flag;
	logic [1:0]  key_state, dbg_op;
	logic [7:0]  key_wdata, xw_data, dbg_wdata, lock_byte;
	logic [15:0] xw_addr, cm_addr, exec_pc, dbg_addr, cur_word, fl_addr;
	logic [15:0] fl_wdata, l_addr, l_wdata;
	int          errors = 0, n_checks = 0, n_prog = 0, n_er = 0, n_err = 0;
	int          n_gr = 0, n_dn = 0, sp, se, sr, sg, sd;

	fpg_guard #(.FLASH_64K(1'b1), .PROG_CYC(PCYC), .ERASE_CYC(ECYC)) u_fpg_guard (
		.core_clk(core_clk), .arst_n(arst_n), .sys_reset(sys_reset),
		.key_wr(key_wr), .key_wdata(key_wdata), .key_state(key_state),
		.store_write_enable(swe), .store_erase_enable(see),
		.block_write_select(bws), .xw_valid(xw_valid), .xw_addr(xw_addr),
		.xw_data(xw_data), .xr_valid(xr_valid), .ram_wr_en(ram_wr_en),
		.ram_rd_en(ram_rd_en), .cm_valid(cm_valid), .cm_addr(cm_addr),
		.exec_pc(exec_pc), .lock_byte(lock_byte), .flash_cur_word(cur_word),
		.core_stall(core_stall), .fl_prog(fl_prog), .fl_erase(fl_erase),
		.fl_mass(fl_mass), .fl_busy(fl_busy), .fl_addr(fl_addr),
		.fl_wdata(fl_wdata), .dbg_valid(dbg_valid), .dbg_op(dbg_op),
		.dbg_addr(dbg_addr), .dbg_wdata(dbg_wdata), .dbg_grant(dbg_grant),
		.dbg_deny(dbg_deny), .flash_err_rst(flash_err_rst),
		.flash_error_flag(flash_error_flag)
	);

	fpg_flash_model #(.FLASH_64K(1'b1)) u_fpg_flash_model (
		.core_clk(core_clk), .fl_prog(fl_prog), .fl_erase(fl_erase),
		.fl_mass(fl_mass), .fl_addr(fl_addr), .fl_wdata(fl_wdata),
		.rd_addr(xw_addr), .cur_word(cur_word), .lock_byte(lock_byte)
	);

	initial begin
		core_clk = 1'b0;
		// 10 MHz stays below the clock that needs the slow read time
		forever #50 core_clk = ~core_clk;
	end

	// Pulse counters so no single-cycle strobe is missed between checks
	always @(posedge core_clk) begin
		n_prog += (fl_prog === 1'b1);
		n_er += (fl_erase === 1'b1);
		n_err += (flash_err_rst === 1'b1);
		n_gr += (dbg_grant === 1'b1);
		n_dn += (dbg_deny === 1'b1);
		if (fl_prog === 1'b1 || fl_erase === 1'b1) begin
			l_addr = fl_addr;
			l_wdata = fl_wdata;
			l_mass = fl_mass;
		end
	end

	task automatic chk(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic print_verdict();
		$display("Checks %0d, mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : print_verdict

	task automatic snap();
		sp = n_prog;
		se = n_er;
		sr = n_err;
		sg = n_gr;
		sd = n_dn;
	endtask : snap

	// Busy is counted over a window longer than any operation
	task automatic settle(input int b, p, e, r, g, d);
		int nb;
		int nf;
		nb = (core_stall === 1'b1);
		nf = (fl_busy === 1'b1);
		repeat (16) begin
			@(negedge core_clk);
			nb += (core_stall === 1'b1);
			nf += (fl_busy === 1'b1);
		end
		chk("busy cycles", 16'(b), 16'(nb));
		chk("flash busy", 16'(b), 16'(nf));
		chk("prog pulses", 16'(p), 16'(n_prog - sp));
		chk("erase pulses", 16'(e), 16'(n_er - se));
		chk("error resets", 16'(r), 16'(n_err - sr));
		chk("grants", 16'(g), 16'(n_gr - sg));
		chk("denials", 16'(d), 16'(n_dn - sd));
	endtask : settle

	task automatic key(input logic [7:0] b, input logic [1:0] exp);
		@(negedge core_clk);
		key_wr = 1'b1;
		key_wdata = b;
		@(negedge core_clk);
		key_wr = 1'b0;
		@(negedge core_clk);
		chk("key state", {14'h0, exp}, {14'h0, key_state});
	endtask : key

	task automatic arm();
		key(8'hA5, 2'b01);
		key(8'hF1, 2'b10);
	endtask : arm

	task automatic xw(input logic [15:0] a, input logic [7:0] d,
		input int b, p, e, r);
		@(negedge core_clk);
		xw_valid = 1'b1;
		xw_addr = a;
		xw_data = d;
		snap();
		#1 rw = ram_wr_en;
		@(negedge core_clk);
		xw_valid = 1'b0;
		settle(b, p, e, r, 0, 0);
	endtask : xw

	task automatic dbg(input fpg_dbg_t op, input logic [15:0] a,
		input int b, e, g, d);
		@(negedge core_clk);
		dbg_valid = 1'b1;
		dbg_op = op;
		dbg_addr = a;
		dbg_wdata = 8'h00;
		snap();
		@(negedge core_clk);
		dbg_valid = 1'b0;
		settle(b, 0, e, 0, g, d);
	endtask : dbg

	task automatic srst(input logic flag);
		@(negedge core_clk);
		sys_reset = 1'b1;
		@(negedge core_clk);
		sys_reset = 1'b0;
		chk("key after reset", 16'h0, {14'h0, key_state});
		chk("error flag", {15'h0, flag}, {15'h0, flash_error_flag});
	endtask : srst

	initial begin
		repeat (6000) @(posedge core_clk);
		errors++;
		print_verdict();
	end

	initial begin
		{arst_n, sys_reset, key_wr, xw_valid, xr_valid, cm_valid} = 6'h00;
		{swe, see, bws, dbg_valid} = 4'h0;
		{key_wdata, xw_data, dbg_wdata, dbg_op} = 26'h0;
		{xw_addr, cm_addr, dbg_addr} = 48'h0;
		exec_pc = 16'h1000;
		repeat (12) @(negedge core_clk);
		arst_n = 1'b1;
		repeat (4) @(negedge core_clk);
		chk("key at start", 16'h0, {14'h0, key_state});
		swe = 1'b1;
		arm();
		xw(16'h1001, 8'h5A, PCYC, 1, 0, 0);
		chk("prog word", 16'h5AFF, l_wdata);
		chk("prog addr", 16'h1000, l_addr);
		chk("relock", 16'h0, {14'h0, key_state});
		arm();
		xw(16'h1001, 8'hA5, PCYC, 1, 0, 0);
		chk("and byte", 16'h0000, {8'h0, u_fpg_flash_model.mem[16'h1001]});
		see = 1'b1;
		arm();
		xw(16'h1123, 8'h77, ECYC, 0, 1, 0);
		chk("page base", 16'h1000, l_addr);
		chk("erased", 16'h00FF, {8'h0, u_fpg_flash_model.mem[16'h1001]});
		{see, bws} = 2'b01;
		arm();
		xw(16'h2000, 8'h11, 0, 0, 0, 0);
		chk("even relock", 16'h0, {14'h0, key_state});
		arm();
		xw(16'h2001, 8'h22, PCYC, 1, 0, 0);
		chk("block word", 16'h2211, l_wdata);
		arm();
		xw(16'h2002, 8'hFF, 0, 0, 0, 0);
		arm();
		xw(16'h2003, 8'h44, PCYC, 1, 0, 0);
		chk("padded word", 16'h44FF, l_wdata);
		{swe, see, bws} = 3'b010;
		xw(16'h1000, 8'h33, 0, 0, 0, 0);
		chk("ram write", 16'h1, {15'h0, rw});
		chk("key kept", 16'h0, {14'h0, key_state});
		swe = 1'b1;
		see = 1'b0;
		xr_valid = 1'b1;
		#1 chk("ram read", 16'h1, {15'h0, ram_rd_en});
		xr_valid = 1'b0;
		u_fpg_flash_model.mem[16'hFBFF] = 8'hFD;
		arm();
		xw(16'h0100, 8'h00, 0, 0, 0, 1);
		xw(16'hFA10, 8'h00, 0, 0, 0, 1);
		chk("key intact", 16'h2, {14'h0, key_state});
		exec_pc = 16'h0000;
		xw(16'h0101, 8'hF0, PCYC, 1, 0, 0);
		arm();
		see = 1'b1;
		xw(16'hFA00, 8'h00, 0, 0, 0, 1);
		see = 1'b0;
		xw(16'hFC00, 8'h00, 0, 0, 0, 1);
		exec_pc = 16'h1000;
		@(negedge core_clk);
		cm_valid = 1'b1;
		cm_addr = 16'h0200;
		snap();
		@(negedge core_clk);
		cm_valid = 1'b0;
		settle(0, 0, 0, 1, 0, 0);
		dbg(FPG_DBG_RD, 16'h0000, 0, 0, 0, 1);
		dbg(FPG_DBG_RD, 16'hFBFF, 0, 0, 1, 0);
		dbg(FPG_DBG_WR, 16'h1000, 0, 0, 1, 0);
		dbg(FPG_DBG_DEV, 16'h0000, ECYC, 1, 1, 0);
		chk("mass erase", 16'h1, {15'h0, l_mass});
		chk("lock cleared", 16'h00FF, {8'h0, lock_byte});
		srst(1'b1);
		key(8'hF1, 2'b11);
		key(8'hA5, 2'b11);
		key(8'hF1, 2'b11);
		xw(16'h1001, 8'h00, 0, 0, 0, 0);
		srst(1'b0);
		key(8'hA5, 2'b01);
		key(8'h12, 2'b11);
		srst(1'b0);
		xw(16'h1001, 8'h00, 0, 0, 0, 0);
		chk("no key lock", 16'h3, {14'h0, key_state});
		print_verdict();
	end
endmodule : test_fpg_guard
